// file: rtl/board_control.sv
// Contract
// - board has up, down and subsystem ports
// - up reset and analyse forwarded to down
// - subsystem outputs OR up with own latches
// - down error ORed with own error upward
// - subsystem error kept local, never sent up
// - module error is open-collector, wire-ORed
// - module reset and analyse go straight through
// - controller drives subsystem lines through latches
// - controller resets subsystem and watches its error
// - processor error output follows its flag
// - slot link 2 feeds next slot link 1
// - pipe jumper loops slot link 1 to 2
// - config jumper picks upstream edge or slot 0
// - switch controllers configure crossbars, form chain
// - crossbar routes any of 32 inputs anywhere
`timescale 1ns/10ps
`default_nettype none
module board_control
	import board_ctl_pkg::*;
#(
	parameter int SLOTS   = SLOT_COUNT,
	parameter int SW_CTLS = SW_CTL_COUNT
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// up port
	input  wire logic                  up_reset_n,
	input  wire logic                  up_analyse_n,
	output logic                       up_error_o,
	output logic                       up_error_oe,
	// down port
	output logic                       down_reset_n,
	output logic                       down_analyse_n,
	input  wire logic                  down_error_n,
	// subsystem port
	output logic                       sub_reset_n,
	output logic                       sub_analyse_n,
	input  wire logic                  sub_error_n,
	// error lines of the other slots, resolved wire-OR
	input  wire logic                  slot_error_n,
	// controlling module in slot 0
	ctl_pins_if.board                  ctl,
	// module pipeline edges
	input  wire logic                  pipe_head_rx,
	output logic                       pipe_head_tx,
	input  wire logic                  pipe_tail_rx,
	output logic                       pipe_tail_tx,
	// slot links 1 and 2
	input  wire logic [SLOTS-1:0]      slot_l1_tx,
	output logic      [SLOTS-1:0]      slot_l1_rx,
	input  wire logic [SLOTS-1:0]      slot_l2_tx,
	output logic      [SLOTS-1:0]      slot_l2_rx,
	input  wire logic [SLOTS-1:0]      pipe_jumper,
	// configuration pipeline
	input  wire logic                  cfg_jumper,
	input  wire logic                  cfg_chain_upstream_rx,
	output logic                       cfg_chain_upstream_tx,
	input  wire logic                  cfg_chain_downstream_rx,
	output logic                       cfg_chain_downstream_tx,
	input  wire logic [SW_CTLS-1:0]    sw_l1_tx,
	output logic      [SW_CTLS-1:0]    sw_l1_rx,
	input  wire logic [SW_CTLS-1:0]    sw_l2_tx,
	output logic      [SW_CTLS-1:0]    sw_l2_rx,
	// crossbar routing orders from a switch controller
	input  wire logic                  xbar_cfg_valid,
	input  wire logic [XBAR_SEL_W-1:0] xbar_cfg_dst,
	input  wire logic [XBAR_SEL_W-1:0] xbar_cfg_src,
	input  wire logic                  xbar_cfg_on,
	// crossbar link wires
	input  wire logic [XBAR_LINKS-1:0] xbar_in,
	output logic      [XBAR_LINKS-1:0] xbar_out
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// active-low OR: the line is asserted when either source is
	function automatic logic or_n(input logic a_n, input logic b_n);
		or_n = a_n & b_n;
	endfunction : or_n

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                                  down_reset_n;   // down port reset
		logic                                  down_analyse_n; // down port analyse
		logic                                  sub_reset_n;    // subsystem port reset
		logic                                  sub_analyse_n;  // subsystem port analyse
		logic                                  up_err;         // high while up error is pulled
		logic                                  child_err_n;    // subsystem error to slot 0
		logic                                  mod_reset_n;    // slot 0 reset
		logic                                  mod_analyse_n;  // slot 0 analyse
		logic [XBAR_LINKS-1:0]                 route_on;       // crossbar output connected
		logic [XBAR_LINKS-1:0][XBAR_SEL_W-1:0] route_src;      // crossbar source per output
	} board_state_t;

	board_state_t s_q; // registered state
	board_state_t s_d; // next state
	logic         own_err_n; // board's own error, wire-OR of its modules

	////////////////////////////////////////////////////////////////////////////
	// system control lines

	// next state of control lines and crossbar table
	always_comb begin
		s_d = s_q;
		// chained boards below see exactly what arrived from above
		s_d.down_reset_n   = up_reset_n;
		s_d.down_analyse_n = up_analyse_n;
		// subsystem gets upper control or the controller's own latches
		s_d.sub_reset_n    = or_n(up_reset_n, ~ctl.child_reset_out);
		s_d.sub_analyse_n  = or_n(up_analyse_n, ~ctl.child_analyse_out);
		// slot 0 pins follow the up port with no logic of their own
		s_d.mod_reset_n    = up_reset_n;
		s_d.mod_analyse_n  = up_analyse_n;
		// error from below merged with ours; subsystem error stays out of it
		s_d.up_err         = ~or_n(down_error_n, own_err_n);
		// subsystem error goes only to the controller that owns it
		s_d.child_err_n    = sub_error_n;
		// a routing order replaces one output's source
		if (xbar_cfg_valid) begin
			s_d.route_on[xbar_cfg_dst]  = xbar_cfg_on;
			s_d.route_src[xbar_cfg_dst] = xbar_cfg_src;
		end
	end

	// controller pulls low only while its enable is high
	assign own_err_n = or_n(slot_error_n, ~(ctl.port_error_oe & ~ctl.port_error_o));

	// register the state; lines come out of reset deasserted, crossbar open
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q                <= '0;
			s_q.down_reset_n   <= LINE_IDLE;
			s_q.down_analyse_n <= LINE_IDLE;
			s_q.sub_reset_n    <= LINE_IDLE;
			s_q.sub_analyse_n  <= LINE_IDLE;
			s_q.child_err_n    <= LINE_IDLE;
			s_q.mod_reset_n    <= LINE_IDLE;
			s_q.mod_analyse_n  <= LINE_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// port drivers; up error is open collector and only ever pulls low
	assign down_reset_n         = s_q.down_reset_n;
	assign down_analyse_n       = s_q.down_analyse_n;
	assign sub_reset_n          = s_q.sub_reset_n;
	assign sub_analyse_n        = s_q.sub_analyse_n;
	assign up_error_o           = LINE_ASSERTED;
	assign up_error_oe          = s_q.up_err;
	assign ctl.port_reset_n     = s_q.mod_reset_n;
	assign ctl.port_analyse_n   = s_q.mod_analyse_n;
	assign ctl.child_error_in_n = s_q.child_err_n;

	////////////////////////////////////////////////////////////////////////////
	// crossbar

	// each output copies its chosen input; an open output idles
	always_comb begin
		for (int o = 0; o < XBAR_LINKS; o++) begin
			xbar_out[o] = s_q.route_on[o] ? xbar_in[s_q.route_src[o]] : LINK_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link pipelines
	// links stay combinational: a register per hop would corrupt the
	// serial protocol timing between modules

	logic [SLOTS-1:0] fwd_in;  // what reaches each slot's link 1 input
	logic [SLOTS-1:0] fwd_out; // what leaves each slot toward the tail
	logic [SLOTS-1:0] rev_in;  // what reaches each slot's link 2 input
	logic [SLOTS-1:0] rev_out; // what leaves each slot toward the head

	// module pipeline with jumpers, and configuration pipeline
	always_comb begin
		// head end: slot 0 link 1 faces the edge or the first controller
		fwd_in[0] = cfg_jumper ? sw_l1_tx[0] : pipe_head_rx;
		for (int k = 0; k < SLOTS; k++) begin
			if (k > 0) begin
				fwd_in[k] = fwd_out[k-1];
			end
			fwd_out[k] = pipe_jumper[k] ? fwd_in[k] : slot_l2_tx[k];
		end
		rev_in[SLOTS-1] = pipe_tail_rx;
		for (int k = SLOTS - 1; k >= 0; k--) begin
			if (k < SLOTS - 1) begin
				rev_in[k] = rev_out[k+1];
			end
			rev_out[k] = pipe_jumper[k] ? rev_in[k] : slot_l1_tx[k];
		end
		slot_l1_rx   = fwd_in;
		slot_l2_rx   = rev_in;
		pipe_tail_tx = fwd_out[SLOTS-1];
		// jumper toward slot 0 disconnects the pipeline head from the edge
		pipe_head_tx          = cfg_jumper ? LINK_IDLE : rev_out[0];
		cfg_chain_upstream_tx = cfg_jumper ? LINK_IDLE : sw_l1_tx[0];
		// controllers chained link 2 to link 1, ends at the edge
		for (int j = 0; j < SW_CTLS; j++) begin
			if (j == 0) begin
				sw_l1_rx[j] = cfg_jumper ? rev_out[0] : cfg_chain_upstream_rx;
			end else begin
				sw_l1_rx[j] = sw_l2_tx[j-1];
			end
			if (j == SW_CTLS - 1) begin
				sw_l2_rx[j] = cfg_chain_downstream_rx;
			end else begin
				sw_l2_rx[j] = sw_l1_tx[j+1];
			end
		end
		cfg_chain_downstream_tx = sw_l2_tx[SW_CTLS-1];
	end

endmodule : board_control
`default_nettype wire

// file: rtl/board_ctl_pkg.sv
package board_ctl_pkg;
	// board geometry
	localparam int          SLOT_COUNT    = 4;     // module slots on the board
	localparam int          SW_CTL_COUNT  = 1;     // switch-controller processors
	localparam int          XBAR_LINKS    = 32;    // crossbar inputs and outputs
	localparam int          XBAR_SEL_W    = 5;     // width of a crossbar index
	localparam logic        LINK_IDLE     = 1'b0;  // level of a disconnected link wire
	// control line levels (active low at the edge)
	localparam logic        LINE_ASSERTED = 1'b0;
	localparam logic        LINE_IDLE     = 1'b1;
	// register bus of the controller module
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  REG_CTRL      = 5'h00; // child reset, child analyse, own error
	localparam logic [4:0]  REG_STATUS    = 5'h04; // sticky events, read only
	localparam logic [4:0]  REG_CLEAR     = 5'h08; // write one to clear, write only
	localparam logic [4:0]  REG_ENABLE    = 5'h0C; // interrupt enables
	localparam logic [4:0]  REG_LIVE      = 5'h10; // live pin levels, read only
	// field layout
	localparam int          CTRL_W          = 3;
	localparam int          CTRL_RESET_BIT  = 0;
	localparam int          CTRL_ANALYSE_BIT= 1;
	localparam int          CTRL_ERROR_BIT  = 2;
	localparam logic [2:0]  CTRL_RESET_VAL  = 3'h0;
	localparam int          EV_W            = 2;
	localparam int          EV_CHILD_ERR    = 0;   // subsystem error line asserted
	localparam int          EV_PORT_RESET   = 1;   // module reset line asserted
	localparam int          LIVE_W          = 3;   // {analyse, reset, child error}, 1 = asserted
	// answers
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : board_ctl_pkg

// file: rtl/ctl_pins_if.sv
`timescale 1ns/10ps
`default_nettype none
// pins between the board and the controlling module in slot 0
interface ctl_pins_if;
	logic port_reset_n;      // board to module, reset
	logic port_analyse_n;    // board to module, analyse
	logic port_error_o;      // module error drive level
	logic port_error_oe;     // module pulls error low while high
	logic child_reset_out;   // module to board, subsystem reset, active high
	logic child_analyse_out; // module to board, subsystem analyse, active high
	logic child_error_in_n;  // board to module, subsystem error
	modport board  (output port_reset_n, output port_analyse_n, input port_error_o, input port_error_oe,
			input child_reset_out, input child_analyse_out, output child_error_in_n);
	modport controller (input port_reset_n, input port_analyse_n, output port_error_o, output port_error_oe,
			output child_reset_out, output child_analyse_out, input child_error_in_n);
endinterface : ctl_pins_if
`default_nettype wire

// file: rtl/subsys_controller.sv
`timescale 1ns/10ps
`default_nettype none
module subsys_controller
	import board_ctl_pkg::*;
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// pins toward the board
	ctl_pins_if.controller         pins,
	// processor pins fed straight from the module pins
	output logic                   proc_reset_n,
	output logic                   proc_analyse_n,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// interrupt
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;     // subsystem latches and own error flag
		logic [EV_W-1:0]   status;   // sticky events
		logic [EV_W-1:0]   enable;   // interrupt enables
		logic              aw_got;   // write address held
		logic              w_got;    // write data held
		logic [ADDR_W-1:0] waddr;    // held write address
		logic [31:0]       wdat;     // held write data
		logic              wlane0;   // low byte lane was enabled
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} ctl_state_t;

	ctl_state_t      s_q; // registered state
	ctl_state_t      s_d; // next state
	logic [EV_W-1:0] ev;  // live event levels

	////////////////////////////////////////////////////////////////////////////
	// register file and bus

	// channel readies: one write and one read in flight at most
	assign awready = ~s_q.aw_got & ~s_q.bvalid;
	assign wready  = ~s_q.w_got & ~s_q.bvalid;
	assign arready = ~s_q.rvalid;

	// events are levels; a sticky bit keeps setting while its line is asserted
	assign ev[EV_CHILD_ERR]  = ~pins.child_error_in_n;
	assign ev[EV_PORT_RESET] = ~pins.port_reset_n;

	// next state
	always_comb begin
		s_d = s_q;
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		// address and data may arrive in either order
		if (awvalid && awready) begin
			s_d.aw_got = 1'b1;
			s_d.waddr  = awaddr;
		end
		if (wvalid && wready) begin
			s_d.w_got  = 1'b1;
			s_d.wdat   = wdata;
			s_d.wlane0 = wstrb[0];
		end
		// both halves present: perform the write and answer next cycle
		if (s_d.aw_got && s_d.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			unique case (s_d.waddr)
				REG_CTRL: begin
					if (s_d.wlane0) begin
						s_d.ctrl = s_d.wdat[CTRL_W-1:0];
					end
				end
				REG_CLEAR: begin
					if (s_d.wlane0) begin
						s_d.status = s_d.status & ~s_d.wdat[EV_W-1:0];
					end
				end
				REG_ENABLE: begin
					if (s_d.wlane0) begin
						s_d.enable = s_d.wdat[EV_W-1:0];
					end
				end
				// read-only registers ignore the data
				REG_STATUS, REG_LIVE: begin
					s_d.bresp = RESP_OKAY;
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		// set wins over a clear in the same cycle
		s_d.status = s_d.status | ev;
		// read capture
		if (arvalid && arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			s_d.rdata  = '0;
			unique case (araddr)
				REG_CTRL:   s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
				REG_STATUS: s_d.rdata[EV_W-1:0]   = s_q.status;
				REG_ENABLE: s_d.rdata[EV_W-1:0]   = s_q.enable;
				REG_LIVE:   s_d.rdata[LIVE_W-1:0] = {~pins.port_analyse_n, ~pins.port_reset_n,
				                                      ~pins.child_error_in_n};
				// clear register is write only and reads zero
				REG_CLEAR:  s_d.rdata = '0;
				default:    s_d.rresp = RESP_SLVERR;
			endcase
		end
	end

	// register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q      <= '0;
			s_q.ctrl <= CTRL_RESET_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign bvalid = s_q.bvalid;
	assign bresp  = s_q.bresp;
	assign rvalid = s_q.rvalid;
	assign rresp  = s_q.rresp;
	assign rdata  = s_q.rdata;
	assign irq    = |(s_q.status & s_q.enable);

	// subsystem lines come from the latches
	assign pins.child_reset_out   = s_q.ctrl[CTRL_RESET_BIT];
	assign pins.child_analyse_out = s_q.ctrl[CTRL_ANALYSE_BIT];
	// error flag drives an open collector that only pulls low
	assign pins.port_error_o      = LINE_ASSERTED;
	assign pins.port_error_oe     = s_q.ctrl[CTRL_ERROR_BIT];
	// no logic between module pins and processor pins
	assign proc_reset_n           = pins.port_reset_n;
	assign proc_analyse_n         = pins.port_analyse_n;

endmodule : subsys_controller
`default_nettype wire

// file: test/board_ctl_properties.sv
`timescale 1ns/10ps
`default_nettype none
// watches the edge ports of the board and the pins of the slot 0 module
module board_ctl_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// up port
	input wire logic up_reset_n,
	input wire logic up_analyse_n,
	input wire logic up_error_oe,
	// down port
	input wire logic down_reset_n,
	input wire logic down_analyse_n,
	input wire logic down_error_n,
	// subsystem port and other slots
	input wire logic sub_reset_n,
	input wire logic sub_analyse_n,
	input wire logic sub_error_n,
	input wire logic slot_error_n,
	// slot 0 module pins
	input wire logic port_reset_n,
	input wire logic port_error_o,
	input wire logic port_error_oe,
	input wire logic child_reset_out,
	input wire logic child_analyse_out,
	input wire logic child_error_in_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////
	// only the subsystem reports an error
	sequence s_sub_err_only;
		!sub_error_n && down_error_n && slot_error_n && !port_error_oe;
	endsequence
	// the first edge after reset is skipped: registers still idle
	property p_down_reset;
		$past(aresetn) |-> down_reset_n == $past(up_reset_n);
	endproperty
	property p_down_analyse;
		$past(aresetn) |-> down_analyse_n == $past(up_analyse_n);
	endproperty
	property p_port_reset;
		$past(aresetn) |-> port_reset_n == $past(up_reset_n);
	endproperty
	property p_sub_reset;
		$past(aresetn) |-> sub_reset_n == $past(up_reset_n && !child_reset_out);
	endproperty
	property p_sub_analyse;
		$past(aresetn) |-> sub_analyse_n == $past(up_analyse_n && !child_analyse_out);
	endproperty
	property p_up_error;
		$past(aresetn) |-> up_error_oe == $past(!down_error_n || !slot_error_n || (port_error_oe && !port_error_o));
	endproperty
	property p_child_error;
		$past(aresetn) |-> child_error_in_n == $past(sub_error_n);
	endproperty
	property p_sub_err_local;
		s_sub_err_only |=> !up_error_oe;
	endproperty
	////////////////////////////////////////////////////////////
	a_down_reset: assert property (p_down_reset)
		else $error("down reset differs from up reset");
	a_down_analyse: assert property (p_down_analyse)
		else $error("down analyse differs from up analyse");
	a_port_reset: assert property (p_port_reset)
		else $error("slot 0 reset differs from up reset");
	a_sub_reset: assert property (p_sub_reset)
		else $error("subsystem reset is not the combined reset");
	a_sub_analyse: assert property (p_sub_analyse)
		else $error("subsystem analyse is not the combined analyse");
	a_up_error: assert property (p_up_error)
		else $error("up error is not the combined error");
	a_child_error: assert property (p_child_error)
		else $error("subsystem error not passed to the module");
	a_sub_err_local: assert property (p_sub_err_local)
		else $error("subsystem error leaked upward");
endmodule : board_ctl_properties
`default_nettype wire

// file: test/hierarchical_board_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
// drives both ends of the slot 0 control pins and judges the board edge
module hierarchical_board_control_tb;
	import board_ctl_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic up_reset_n, up_analyse_n, down_error_n, sub_error_n, slot_error_n;
	logic up_error_oe, down_reset_n, down_analyse_n, sub_reset_n, sub_analyse_n;
	logic head_rx, tail_rx, head_tx, tail_tx, cfg_jumper, cup_rx, cdn_rx, cup_tx, cdn_tx;
	logic [3:0] l1_tx, l1_rx, l2_tx, l2_rx, jumper;
	logic [0:0] sw1_tx, sw1_rx, sw2_tx, sw2_rx;
	logic xv, xon, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, proc_reset_n, proc_analyse_n;
	logic [4:0] xdst, xsrc, awaddr, araddr;
	logic [31:0] xin, xout, wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int n_errors = 0;
	int tests_run = 0;
	ctl_pins_if pins ();
	board_control i_board_control (.aclk(aclk), .aresetn(aresetn), .up_reset_n(up_reset_n),
		.up_analyse_n(up_analyse_n), .up_error_o(), .up_error_oe(up_error_oe), .down_reset_n(down_reset_n),
		.down_analyse_n(down_analyse_n), .down_error_n(down_error_n), .sub_reset_n(sub_reset_n),
		.sub_analyse_n(sub_analyse_n), .sub_error_n(sub_error_n), .slot_error_n(slot_error_n), .ctl(pins),
		.pipe_head_rx(head_rx), .pipe_head_tx(head_tx), .pipe_tail_rx(tail_rx), .pipe_tail_tx(tail_tx),
		.slot_l1_tx(l1_tx), .slot_l1_rx(l1_rx), .slot_l2_tx(l2_tx), .slot_l2_rx(l2_rx), .pipe_jumper(jumper),
		.cfg_jumper(cfg_jumper), .cfg_chain_upstream_rx(cup_rx), .cfg_chain_upstream_tx(cup_tx),
		.cfg_chain_downstream_rx(cdn_rx), .cfg_chain_downstream_tx(cdn_tx), .sw_l1_tx(sw1_tx),
		.sw_l1_rx(sw1_rx), .sw_l2_tx(sw2_tx), .sw_l2_rx(sw2_rx), .xbar_cfg_valid(xv), .xbar_cfg_dst(xdst),
		.xbar_cfg_src(xsrc), .xbar_cfg_on(xon), .xbar_in(xin), .xbar_out(xout));
	subsys_controller i_subsys_controller (.aclk(aclk), .aresetn(aresetn), .pins(pins),
		.proc_reset_n(proc_reset_n), .proc_analyse_n(proc_analyse_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
	board_ctl_properties i_props (.aclk(aclk), .aresetn(aresetn), .up_reset_n(up_reset_n),
		.up_analyse_n(up_analyse_n), .up_error_oe(up_error_oe), .down_reset_n(down_reset_n),
		.down_analyse_n(down_analyse_n), .down_error_n(down_error_n), .sub_reset_n(sub_reset_n),
		.sub_analyse_n(sub_analyse_n), .sub_error_n(sub_error_n), .slot_error_n(slot_error_n),
		.port_reset_n(pins.port_reset_n), .port_error_o(pins.port_error_o), .port_error_oe(pins.port_error_oe),
		.child_reset_out(pins.child_reset_out), .child_analyse_out(pins.child_analyse_out),
		.child_error_in_n(pins.child_error_in_n));
	////////////////////////////////////////////////////////////
	// free running clock
	always #25 aclk = ~aclk;
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// let n edges pass, then look after they land
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : settle
	// address and data offered together, each dropped once taken
	task automatic axi_write(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rsp);
		bit done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			done = bvalid;
			rsp = bresp;
		end
		bready <= 1'b0;
	endtask : axi_write
	// one read, data taken at the edge that sees rvalid
	task automatic axi_read(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rsp);
		bit done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			done = rvalid;
			v = rdata;
			rsp = rresp;
		end
		rready <= 1'b0;
	endtask : axi_read
	////////////////////////////////////////////////////////////
	// up port control reaches down, subsystem and the processor
	task automatic t_forward;
		@(posedge aclk);
		up_reset_n <= 1'b0;
		up_analyse_n <= 1'b0;
		settle(2);
		check({down_reset_n, down_analyse_n}, 2'h0);
		check({sub_reset_n, sub_analyse_n}, 2'h0);
		check({proc_reset_n, proc_analyse_n}, 2'h0);
		@(posedge aclk);
		up_reset_n <= 1'b1;
		up_analyse_n <= 1'b1;
		settle(2);
		check({down_reset_n, down_analyse_n, sub_reset_n, sub_analyse_n}, 4'hF);
		$display("forward test done");
	endtask : t_forward
	// subsystem lines from the controller latches only
	task automatic t_latch;
		axi_write(REG_CTRL, 32'h1, r);
		settle(2);
		check({r, sub_reset_n, sub_analyse_n, down_reset_n}, {RESP_OKAY, 3'h3});
		axi_write(REG_CTRL, 32'h2, r);
		settle(2);
		check({sub_reset_n, sub_analyse_n, down_analyse_n}, 3'h5);
		axi_read(REG_CTRL, d, r);
		check(d, 32'h2);
		axi_write(REG_CTRL, 32'h0, r);
		settle(2);
		check({sub_reset_n, sub_analyse_n}, 2'h3);
		$display("latch test done");
	endtask : t_latch
	// error merging toward the up port
	task automatic t_error;
		@(posedge aclk);
		sub_error_n <= 1'b0;
		settle(2);
		check({up_error_oe, pins.child_error_in_n}, 2'h0);
		@(posedge aclk);
		sub_error_n <= 1'b1;
		down_error_n <= 1'b0;
		settle(2);
		check(up_error_oe, 1'b1);
		@(posedge aclk);
		down_error_n <= 1'b1;
		slot_error_n <= 1'b0;
		settle(2);
		check(up_error_oe, 1'b1);
		@(posedge aclk);
		slot_error_n <= 1'b1;
		axi_write(REG_CTRL, 32'h4, r);
		settle(2);
		check({pins.port_error_oe, pins.port_error_o, up_error_oe}, 3'h5);
		axi_write(REG_CTRL, 32'h0, r);
		settle(2);
		check(up_error_oe, 1'b0);
		$display("error test done");
	endtask : t_error
	// interrupt set, masked, cleared; refused accesses
	task automatic t_irq;
		axi_write(REG_CLEAR, 32'h3, r);
		axi_write(REG_ENABLE, 32'h1, r);
		@(posedge aclk);
		sub_error_n <= 1'b0;
		settle(3);
		check(irq, 1'b1);
		axi_read(REG_STATUS, d, r);
		check(d, 32'h1);
		axi_write(REG_ENABLE, 32'h0, r);
		settle(1);
		check(irq, 1'b0);
		axi_write(REG_ENABLE, 32'h1, r);
		settle(1);
		check(irq, 1'b1);
		@(posedge aclk);
		sub_error_n <= 1'b1;
		settle(2);
		axi_write(REG_CLEAR, 32'h1, r);
		settle(1);
		check(irq, 1'b0);
		axi_write(REG_STATUS, 32'h3, r);
		axi_read(REG_STATUS, d, r);
		check(d, 32'h0);
		check(r, RESP_OKAY);
		axi_write(5'h1C, 32'h1, r);
		check(r, RESP_SLVERR);
		axi_read(5'h14, d, r);
		check(d, 32'h0);
		check(r, RESP_SLVERR);
		$display("interrupt test done");
	endtask : t_irq
	// pipeline, pipe jumper and configuration jumper
	task automatic t_links;
		for (int k = 0; k < 4; k++) begin
			@(posedge aclk);
			l2_tx <= 4'h1 << k;
			head_rx <= k[0];
			#1;
			check({tail_tx, l1_rx}, {l2_tx[3], l2_tx[2:0], head_rx});
		end
		@(posedge aclk);
		jumper <= 4'h2;
		l2_tx <= 4'h1;
		#1;
		check(l1_rx[2], 1'b1);
		@(posedge aclk);
		cup_rx <= 1'b1;
		sw2_tx <= 1'b1;
		#1;
		check({sw1_rx, cdn_tx}, 2'h3);
		@(posedge aclk);
		cfg_jumper <= 1'b1;
		jumper <= 4'h0;
		l1_tx <= 4'h1;
		sw1_tx <= 1'b1;
		head_rx <= 1'b0;
		#1;
		check({sw1_rx, l1_rx[0], head_tx, cup_tx}, 4'hC);
		$display("link test done");
	endtask : t_links
	// one crossbar order, taken on the edge that sees it
	task automatic xroute(input logic [4:0] dst, input logic [4:0] src, input logic on);
		@(posedge aclk);
		xv <= 1'b1;
		xdst <= dst;
		xsrc <= src;
		xon <= on;
	endtask : xroute
	task automatic t_xbar;
		xroute(5'h03, 5'h07, 1'b1);
		xroute(5'h1F, 5'h00, 1'b1);
		xroute(5'h00, 5'h1F, 1'b1);
		xin <= 32'h0000_0080;
		@(posedge aclk);
		xv <= 1'b0;
		#1;
		check(xout, 32'h0000_0008);
		xroute(5'h03, 5'h07, 1'b0);
		xin <= 32'h8000_0001;
		@(posedge aclk);
		xv <= 1'b0;
		#1;
		check(xout, 32'h8000_0001);
		$display("crossbar test done");
	endtask : t_xbar
	// counts, verdict, end of run
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// a hung handshake ends here
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
	// main sequence
	initial begin
		{up_reset_n, up_analyse_n, down_error_n, sub_error_n, slot_error_n} = 5'h1F;
		{head_rx, tail_rx, cfg_jumper, cup_rx, cdn_rx, xv, xon} = 7'h0;
		{l1_tx, l2_tx, jumper, sw1_tx, sw2_tx, xdst, xsrc, xin} = '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_forward();
		t_latch();
		t_error();
		t_irq();
		t_links();
		t_xbar();
		complete_run();
	end
endmodule : hierarchical_board_control_tb
`default_nettype wire
